// *** rtl/ltt_regs.svh ***
// codes, reply markers and timing counts for the line test-mode control
`ifndef LTT_REGS_SVH
`define LTT_REGS_SVH

// command channel codes
`define CMD_MASTER_CLEAR 4'h1
`define CMD_LT_POWER_DOWN 4'h3
`define CMD_SINGLE_PULSE 4'h5
`define CMD_DATA_THROUGH 4'h6

// first byte of every register read reply
`define MON_REPLY_BYTE 8'h80

// single-pulse spacing and pulse level
`define CLK_PERIOD_NS 8
`define SINGLE_PULSE_SPACING_NS 1500000
`define SINGLE_PULSE_SPACING_CYC (`SINGLE_PULSE_SPACING_NS / `CLK_PERIOD_NS)
`define PULSE_LEVEL_POS 3'sd3
`define PULSE_LEVEL_NEG -3'sd3

`endif

// *** rtl/ltt_pkg.sv ***
// types shared by the line test-mode control modules
package ltt_pkg;
   typedef enum logic [1:0] {
      MODE_NORMAL,
      MODE_SINGLE_PULSE,
      MODE_DATA_THROUGH,
      MODE_TEST
   } mode_t;
   typedef enum logic [1:0] {
      CAUSE_NONE,
      CAUSE_RESET,
      CAUSE_SUPPLY,
      CAUSE_POWER_DOWN
   } cause_t;
   typedef enum logic [1:0] {
      MON_IDLE,
      MON_FIRST,
      MON_SECOND
   } mon_state_t;
endpackage

// *** rtl/pulse_spacer.sv ***
// fires one strobe every SPACING_CYC cycles while enabled
`timescale 1ns/1ns
`default_nettype none
module pulse_spacer #(
   parameter int SPACING_CYC = 187500
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic reset,
   // control
   input wire logic enable,
   // strobe
   output logic fire
);
   localparam int CW = $clog2(SPACING_CYC + 1);
   localparam logic [CW-1:0] LAST = CW'(SPACING_CYC - 1);

   logic [CW-1:0] count_r;

   // restart from zero on every enable so the first pulse is a full gap away
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         count_r <= '0;
      end else if (!enable || count_r == LAST) begin
         count_r <= '0;
      end else begin
         count_r <= count_r + 1'b1;
      end
   end

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         fire <= 1'b0;
      end else begin
         fire <= enable && count_r == LAST;
      end
   end
endmodule // pulse_spacer
`default_nettype wire

// *** rtl/monitor_reply.sv ***
// sends one or two queued monitor words with a valid/ready handshake
`timescale 1ns/1ns
`default_nettype none
module monitor_reply
   import ltt_pkg::*;
(
   // clock and reset
   input wire logic clk_sys,
   input wire logic reset,
   // load side
   input wire logic load,
   input wire logic twoWords,
   input wire logic [15:0] word0,
   input wire logic [15:0] word1,
   output logic busy,
   // transmit side
   output logic txValid,
   output logic [15:0] txData,
   input wire logic txReady
);
   mon_state_t state_r;
   logic [15:0] second_r;

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         state_r <= MON_IDLE;
         txData <= 16'h0000;
         second_r <= 16'h0000;
      end else begin
         unique case (state_r)
            MON_IDLE: begin
               if (load) begin
                  txData <= word0;
                  second_r <= word1;
                  state_r <= twoWords ? MON_SECOND : MON_FIRST;
               end
            end
            MON_SECOND: begin
               if (txReady) begin
                  txData <= second_r;
                  state_r <= MON_FIRST;
               end
            end
            MON_FIRST: begin
               if (txReady) begin
                  state_r <= MON_IDLE;
               end
            end
            default: begin
               state_r <= MON_IDLE;
            end
         endcase
      end
   end

   assign txValid = state_r != MON_IDLE;
   assign busy = state_r != MON_IDLE;
endmodule // monitor_reply
`default_nettype wire

// *** rtl/line_transceiver_test_mode_control.sv ***
// test-mode selection, indication and monitor self-test/register read for the line transceiver
//
// How it works
// RULE_01 - single-pulse mode sends alternating +3/-3 pulses every 1.5 ms
// RULE_02 - single-pulse entered by pins 1/1 or command 0101, identically
// RULE_03 - single-pulse reports inactive in line-terminal, deactivation request in network-terminal
// RULE_04 - data-through forces activation machine into Transparent from any state
// RULE_05 - data-through entered by pins 0/1 or command 0110
// RULE_06 - pin-selected data-through still acts on commands, e.g. analog loop-back
// RULE_07 - master reset: Test state, line silent, coefficients cleared
// RULE_08 - Test state refuses any line activation in every mode
// RULE_09 - master reset entered by pins 0/0 or command 0001, equivalently
// RULE_10 - Test state reports inactive in line-terminal, deactivation request in network-terminal
// RULE_11 - line-terminal: supply pin or command 0011 also enter Test state
// RULE_12 - Test via supply pin reports power-down instead of inactive
// RULE_13 - Test via power-down command reports inactive and asserts supply disable
// RULE_14 - terminal starts self-test with check request; no internal test runs
// RULE_15 - correctly received check request is answered with check passed
// RULE_16 - self-test answered only in network-terminal modes
// RULE_17 - controller reads a register with access byte then address byte
// RULE_18 - register value returned as two separate two-byte messages
`include "ltt_regs.svh"
`timescale 1ns/1ns
`default_nettype none
module line_transceiver_test_mode_control
   import ltt_pkg::*;
#(
   parameter int SPACING_CYC = `SINGLE_PULSE_SPACING_CYC,
   parameter logic [3:0] IND_INACTIVE = 4'hF,
   parameter logic [3:0] IND_DEACT_REQ = 4'h0,
   parameter logic [3:0] IND_POWER_DOWN = 4'h3,
   parameter logic [3:0] CMD_ANALOG_LOOP = 4'h8,
   parameter logic [15:0] CHECK_REQ_WORD = 16'h0002,
   parameter logic [15:0] CHECK_PASS_WORD = 16'h0003,
   parameter logic [7:0] REG_ACCESS_BYTE = 8'h40
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic reset,
   // mode pins and operating mode
   input wire logic chipResetPin,
   input wire logic testPulsePin,
   input wire logic supplySelectPin,
   input wire logic ntMode,
   // command / indication channel
   input wire logic [3:0] ciCmd,
   input wire logic [3:0] coreInd,
   output logic [3:0] ciInd,
   // line and core control
   output logic pulseStrobe,
   output logic signed [2:0] pulseLevel,
   output logic forceTransparent,
   output logic lineSilent,
   output logic coefClear,
   output logic activationRefuse,
   output logic analogLoopClose,
   output logic supplyDisablePin,
   // coefficient register read port
   output logic [7:0] coefAddr,
   input wire logic [15:0] coefData,
   // monitor receive
   input wire logic monRxValid,
   input wire logic [15:0] monRxData,
   output logic monRxReady,
   // monitor transmit
   output logic monTxValid,
   output logic [15:0] monTxData,
   input wire logic monTxReady
);
   // ----------------------------------------------------------------
   // mode selection
   // ----------------------------------------------------------------
   mode_t mode_r;
   mode_t mode_nxt;
   cause_t cause_r;
   cause_t cause_nxt;

   always_comb begin
      mode_nxt = MODE_NORMAL;
      cause_nxt = CAUSE_NONE;
      if (chipResetPin && testPulsePin) begin
         mode_nxt = MODE_SINGLE_PULSE; // see RULE_02
      end else if (!chipResetPin && testPulsePin) begin
         mode_nxt = MODE_DATA_THROUGH; // see RULE_05
      end else if (!chipResetPin && !testPulsePin) begin
         mode_nxt = MODE_TEST; // see RULE_09
         cause_nxt = CAUSE_RESET;
      end else if (!ntMode && supplySelectPin) begin
         mode_nxt = MODE_TEST; // see RULE_11
         cause_nxt = CAUSE_SUPPLY;
      end else begin
         if (ciCmd == `CMD_SINGLE_PULSE) begin
            mode_nxt = MODE_SINGLE_PULSE; // see RULE_02
         end else if (ciCmd == `CMD_DATA_THROUGH) begin
            mode_nxt = MODE_DATA_THROUGH; // see RULE_05
         end else if (ciCmd == `CMD_MASTER_CLEAR) begin
            mode_nxt = MODE_TEST; // see RULE_09
            cause_nxt = CAUSE_RESET;
         end else if (!ntMode && ciCmd == `CMD_LT_POWER_DOWN) begin
            mode_nxt = MODE_TEST; // see RULE_11
            cause_nxt = CAUSE_POWER_DOWN;
         end
      end
   end

   // pins win over commands; the supply path is ignored in network-terminal modes
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         mode_r <= MODE_TEST;
         cause_r <= CAUSE_RESET;
      end else begin
         mode_r <= mode_nxt;
         cause_r <= cause_nxt;
      end
   end

   // ----------------------------------------------------------------
   // line and core control
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         forceTransparent <= 1'b0;
         lineSilent <= 1'b1;
         coefClear <= 1'b1;
         activationRefuse <= 1'b1;
         supplyDisablePin <= 1'b0;
      end else begin
         forceTransparent <= mode_nxt == MODE_DATA_THROUGH; // see RULE_04
         lineSilent <= mode_nxt == MODE_TEST; // see RULE_07
         coefClear <= mode_nxt == MODE_TEST; // see RULE_07
         activationRefuse <= mode_nxt == MODE_TEST; // see RULE_08
         supplyDisablePin <= cause_nxt == CAUSE_POWER_DOWN; // see RULE_13
      end
   end

   // commands stay live under pin data-through; master clear opens the loop
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         analogLoopClose <= 1'b0;
      end else if (ciCmd == CMD_ANALOG_LOOP) begin
         analogLoopClose <= 1'b1; // see RULE_06
      end else if (ciCmd == `CMD_MASTER_CLEAR) begin
         analogLoopClose <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // single pulses
   // ----------------------------------------------------------------
   logic spacerFire;

   pulse_spacer #(
      .SPACING_CYC(SPACING_CYC)
   ) u_spacer (
      .clk_sys(clk_sys),
      .reset(reset),
      .enable(mode_r == MODE_SINGLE_PULSE),
      .fire(spacerFire)
   );

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         pulseStrobe <= 1'b0;
         pulseLevel <= `PULSE_LEVEL_NEG;
      end else begin
         pulseStrobe <= spacerFire; // see RULE_01
         if (spacerFire) begin
            pulseLevel <= (pulseLevel == `PULSE_LEVEL_POS) ?
               `PULSE_LEVEL_NEG : `PULSE_LEVEL_POS; // see RULE_01
         end
      end
   end

   // ----------------------------------------------------------------
   // indication channel
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         ciInd <= IND_INACTIVE;
      end else if (mode_r == MODE_SINGLE_PULSE) begin
         ciInd <= ntMode ? IND_DEACT_REQ : IND_INACTIVE; // see RULE_03
      end else if (mode_r == MODE_TEST) begin
         if (ntMode) begin
            ciInd <= IND_DEACT_REQ; // see RULE_10
         end else if (cause_r == CAUSE_SUPPLY) begin
            ciInd <= IND_POWER_DOWN; // see RULE_12
         end else begin
            ciInd <= IND_INACTIVE; // see RULE_10 RULE_13
         end
      end else begin
         ciInd <= coreInd;
      end
   end

   // ----------------------------------------------------------------
   // monitor channel: self-test and register read
   // ----------------------------------------------------------------
   logic replyBusy;
   logic rxTake;
   logic checkHit;
   logic readHit;
   logic readPending_r;
   logic replyLoad;
   logic replyTwo;
   logic [15:0] replyWord0;
   logic [15:0] replyWord1;

   // one request at a time; a pending read also blocks so the address holds
   assign monRxReady = !replyBusy && !readPending_r;
   assign rxTake = monRxValid && monRxReady;
   // no internal test runs; a clean request is simply acknowledged
   assign checkHit = rxTake && ntMode && monRxData == CHECK_REQ_WORD; // see RULE_14 RULE_16
   assign readHit = rxTake && monRxData[15:8] == REG_ACCESS_BYTE; // see RULE_17

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         readPending_r <= 1'b0;
         coefAddr <= 8'h00;
      end else begin
         readPending_r <= readHit;
         if (readHit) begin
            coefAddr <= monRxData[7:0];
         end
      end
   end

   // core data is sampled one cycle after the address is presented
   always_comb begin
      replyLoad = checkHit || readPending_r;
      replyTwo = readPending_r;
      replyWord0 = CHECK_PASS_WORD; // see RULE_15
      replyWord1 = 16'h0000;
      if (readPending_r) begin
         replyWord0 = {`MON_REPLY_BYTE, coefData[15:8]}; // see RULE_18
         replyWord1 = {`MON_REPLY_BYTE, coefData[7:0]}; // see RULE_18
      end
   end

   monitor_reply u_reply (
      .clk_sys(clk_sys),
      .reset(reset),
      .load(replyLoad),
      .twoWords(replyTwo),
      .word0(replyWord0),
      .word1(replyWord1),
      .busy(replyBusy),
      .txValid(monTxValid),
      .txData(monTxData),
      .txReady(monTxReady)
   );

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   sequence s_check_in_nt;
      monRxValid && monRxReady && ntMode && monRxData == CHECK_REQ_WORD;
   endsequence

   sequence s_read_in;
      monRxValid && monRxReady && monRxData[15:8] == REG_ACCESS_BYTE;
   endsequence

   sequence s_reply_high;
      monTxValid && monTxData[15:8] == `MON_REPLY_BYTE;
   endsequence

   a_pulse_gap: assert property (@(posedge clk_sys) disable iff (reset) // see RULE_01
      pulseStrobe |=> !pulseStrobe [*8])
      else $error("single pulses too close together");

   a_pulse_alternate: assert property (@(posedge clk_sys) disable iff (reset) // see RULE_01
      pulseStrobe |-> pulseLevel != $past(pulseLevel) &&
      (pulseLevel == `PULSE_LEVEL_POS || pulseLevel == `PULSE_LEVEL_NEG))
      else $error("single pulse level did not alternate");

   a_pin_single_pulse: assert property (@(posedge clk_sys) disable iff (reset) // see RULE_02
      chipResetPin && testPulsePin |=> mode_r == MODE_SINGLE_PULSE)
      else $error("pins 1/1 did not select single pulse");

   a_pin_data_through: assert property (@(posedge clk_sys) disable iff (reset) // see RULE_05
      !chipResetPin && testPulsePin |=> forceTransparent && !lineSilent)
      else $error("pins 0/1 did not force transparent");

   a_pin_master_reset: assert property (@(posedge clk_sys) disable iff (reset) // see RULE_09
      !chipResetPin && !testPulsePin |=> lineSilent && coefClear && activationRefuse)
      else $error("pins 0/0 did not enter test state");

   a_cmd_master_reset: assert property (@(posedge clk_sys) disable iff (reset) // see RULE_09
      chipResetPin && !testPulsePin && ciCmd == `CMD_MASTER_CLEAR
      |=> mode_r == MODE_TEST && activationRefuse && coefClear)
      else $error("master clear command did not enter test state");

   a_test_nt_ind: assert property (@(posedge clk_sys) disable iff (reset) // see RULE_10
      mode_r == MODE_TEST && ntMode |=> ciInd == IND_DEACT_REQ)
      else $error("test state in nt mode must report deactivation request");

   a_pulse_lt_ind: assert property (@(posedge clk_sys) disable iff (reset) // see RULE_03
      mode_r == MODE_SINGLE_PULSE && !ntMode |=> ciInd == IND_INACTIVE)
      else $error("single pulse in lt mode must report inactive");

   a_supply_pin_ind: assert property (@(posedge clk_sys) disable iff (reset) // see RULE_12
      mode_r == MODE_TEST && cause_r == CAUSE_SUPPLY && !ntMode
      |=> ciInd == IND_POWER_DOWN)
      else $error("supply pin test state must report power down");

   a_power_down_dis: assert property (@(posedge clk_sys) disable iff (reset) // see RULE_13
      chipResetPin && !testPulsePin && !supplySelectPin && !ntMode &&
      ciCmd == `CMD_LT_POWER_DOWN |=> supplyDisablePin && lineSilent && mode_r == MODE_TEST)
      else $error("power down command must disable supply and enter test state");

   a_pd_cmd_ind: assert property (@(posedge clk_sys) disable iff (reset) // see RULE_13
      mode_r == MODE_TEST && cause_r == CAUSE_POWER_DOWN && !ntMode |=> ciInd == IND_INACTIVE)
      else $error("power down command test state must report inactive");

   a_check_reply: assert property (@(posedge clk_sys) disable iff (reset) // see RULE_15
      s_check_in_nt |=> monTxValid && monTxData == CHECK_PASS_WORD)
      else $error("check request not answered with check passed");

   a_check_lt_quiet: assert property (@(posedge clk_sys) disable iff (reset) // see RULE_16
      monRxValid && monRxReady && !ntMode && monRxData == CHECK_REQ_WORD
      |=> !monTxValid)
      else $error("check request answered outside nt mode");

   a_read_two_words: assert property (@(posedge clk_sys) disable iff (reset) // see RULE_18
      s_read_in |=> ##1 s_reply_high ##1 (monTxValid && monTxData[15:8] == `MON_REPLY_BYTE))
      else $error("register read did not return two reply words");

   a_read_addr: assert property (@(posedge clk_sys) disable iff (reset) // see RULE_17
      s_read_in |=> coefAddr == $past(monRxData[7:0]))
      else $error("register address not taken from second byte");

   a_test_refuse: assert property (@(posedge clk_sys) disable iff (reset) // see RULE_08
      mode_r == MODE_TEST |-> activationRefuse && lineSilent && coefClear)
      else $error("test state must refuse activation and keep the line silent");

   a_through_forced: assert property (@(posedge clk_sys) disable iff (reset) // see RULE_04
      mode_r == MODE_DATA_THROUGH |-> forceTransparent && !lineSilent && !activationRefuse)
      else $error("data-through must force the transparent state");

   a_loop_close: assert property (@(posedge clk_sys) disable iff (reset) // see RULE_06
      ciCmd == CMD_ANALOG_LOOP |=> analogLoopClose)
      else $error("analog loop command did not close the loop");

   a_pulse_nt_ind: assert property (@(posedge clk_sys) disable iff (reset) // see RULE_03
      mode_r == MODE_SINGLE_PULSE && ntMode |=> ciInd == IND_DEACT_REQ)
      else $error("single pulse in nt mode must report deactivation request");
endmodule // line_transceiver_test_mode_control
`default_nettype wire

// *** verification/mon_ctrl_model.sv ***
// monitor-channel controller and coefficient source facing the test-mode control
`timescale 1ns/1ns
`default_nettype none
module mon_ctrl_model (
   // clock and reset
   input wire logic clk_sys,
   input wire logic reset,
   // monitor words towards the block
   input wire logic monRxReady,
   output logic monRxValid,
   output logic [15:0] monRxData,
   // monitor words from the block
   input wire logic monTxValid,
   input wire logic [15:0] monTxData,
   output logic monTxReady,
   // core register source
   input wire logic [7:0] coefAddr,
   output logic [15:0] coefData
);
   logic slow;
   logic [1:0] stallCnt;
   logic [15:0] txWords[$];
   initial begin
      monRxValid = 1'b0;
      monRxData = 16'h0000;
      monTxReady = 1'b1;
      slow = 1'b0;
      stallCnt = 2'd0;
   end
   // distinct halves so a swapped byte order shows
   assign coefData = {coefAddr, ~coefAddr};
   // one word held until taken; released data shows its inverse
   task send_word(input logic [15:0] w);
      @(negedge clk_sys);
      monRxValid = 1'b1;
      monRxData = w;
      do @(posedge clk_sys); while (monRxReady !== 1'b1);
      @(negedge clk_sys);
      monRxValid = 1'b0;
      monRxData = ~w;
   endtask
   // slow mode grants ready one cycle in four
   always @(negedge clk_sys) begin
      stallCnt <= stallCnt + 2'd1;
      monTxReady <= !slow || stallCnt == 2'd3;
   end
   always @(posedge clk_sys) begin
      if (!reset && monTxValid === 1'b1 && monTxReady)
         txWords.push_back(monTxData);
   end
endmodule // mon_ctrl_model
`default_nettype wire

// *** verification/tb_line_transceiver_test_mode_control.sv ***
// self-checking bench for the line test-mode control
`include "ltt_regs.svh"
`timescale 1ns/1ns
`default_nettype none
`define CHECK_EQ(got, exp) begin checks_done++; if ((got) !== (exp)) begin n_fail++; \
   $display("wrong value at %0t: got %h expected %h", $time, got, exp); end end
module tb_line_transceiver_test_mode_control;
   import ltt_pkg::*;
   localparam int SPC = 20;
   logic clk_sys = 1'b0, reset = 1'b1;
   logic chipResetPin = 1'b1, testPulsePin = 1'b0, supplySelectPin = 1'b0, ntMode = 1'b0;
   logic [3:0] ciCmd = 4'h0, coreInd = 4'h7;
   logic [3:0] ciInd;
   logic pulseStrobe, forceTransparent, lineSilent, coefClear, activationRefuse;
   logic analogLoopClose, supplyDisablePin, monRxValid, monRxReady, monTxValid, monTxReady;
   logic signed [2:0] pulseLevel;
   logic [7:0] coefAddr;
   logic [15:0] coefData, monRxData, monTxData;
   int n_fail = 0, checks_done = 0, cycles = 0;
   always #4 clk_sys = ~clk_sys;
   line_transceiver_test_mode_control #(.SPACING_CYC(SPC)) i_dut (.clk_sys(clk_sys),
      .reset(reset), .chipResetPin(chipResetPin), .testPulsePin(testPulsePin),
      .supplySelectPin(supplySelectPin), .ntMode(ntMode), .ciCmd(ciCmd), .coreInd(coreInd),
      .ciInd(ciInd), .pulseStrobe(pulseStrobe), .pulseLevel(pulseLevel),
      .forceTransparent(forceTransparent), .lineSilent(lineSilent), .coefClear(coefClear),
      .activationRefuse(activationRefuse), .analogLoopClose(analogLoopClose),
      .supplyDisablePin(supplyDisablePin), .coefAddr(coefAddr), .coefData(coefData),
      .monRxValid(monRxValid), .monRxData(monRxData), .monRxReady(monRxReady),
      .monTxValid(monTxValid), .monTxData(monTxData), .monTxReady(monTxReady));
   mon_ctrl_model i_partner (.clk_sys(clk_sys), .reset(reset), .monRxReady(monRxReady),
      .monRxValid(monRxValid), .monRxData(monRxData), .monTxValid(monTxValid),
      .monTxData(monTxData), .monTxReady(monTxReady), .coefAddr(coefAddr),
      .coefData(coefData));
   task wrap_up;
      $display("checks %0d, mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   // hang guard, well beyond the sum of all scenarios
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 20000) begin
         n_fail++;
         wrap_up();
      end
   end
   // apply inputs, let the two-cycle indication path settle
   task apply(input logic cr, tp, ss, nt, input logic [3:0] cmd);
      @(negedge clk_sys);
      chipResetPin = cr;
      testPulsePin = tp;
      supplySelectPin = ss;
      ntMode = nt;
      ciCmd = cmd;
      repeat (3) @(negedge clk_sys);
   endtask
   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   task test_master_reset;
      logic [3:0] cmds[2];
      cmds = '{4'h0, `CMD_MASTER_CLEAR};
      for (int nt = 0; nt < 2; nt++) begin
         for (int k = 0; k < 2; k++) begin
            if (k == 0) apply(1'b0, 1'b0, 1'b0, nt[0], 4'h0);
            else apply(1'b1, 1'b0, 1'b0, nt[0], cmds[1]);
            `CHECK_EQ(lineSilent, 1'b1)
            `CHECK_EQ(coefClear, 1'b1)
            `CHECK_EQ(activationRefuse, 1'b1)
            `CHECK_EQ(ciInd, nt ? i_dut.IND_DEACT_REQ : i_dut.IND_INACTIVE)
         end
      end
   endtask
   task test_data_through;
      for (int k = 0; k < 2; k++) begin
         if (k == 0) apply(1'b0, 1'b1, 1'b0, 1'b1, 4'h0);
         else apply(1'b1, 1'b0, 1'b0, 1'b1, `CMD_DATA_THROUGH);
         `CHECK_EQ(forceTransparent, 1'b1)
         `CHECK_EQ(lineSilent, 1'b0)
         `CHECK_EQ(ciInd, coreInd)
      end
      apply(1'b0, 1'b1, 1'b0, 1'b0, i_dut.CMD_ANALOG_LOOP);
      `CHECK_EQ(analogLoopClose, 1'b1)
      `CHECK_EQ(forceTransparent, 1'b1)
      apply(1'b0, 1'b1, 1'b0, 1'b0, `CMD_MASTER_CLEAR);
      `CHECK_EQ(analogLoopClose, 1'b0)
      `CHECK_EQ(lineSilent, 1'b0)
   endtask
   task test_single_pulse;
      int gap;
      logic signed [2:0] expLvl;
      for (int k = 0; k < 2; k++) begin
         if (k == 0) apply(1'b1, 1'b1, 1'b0, k[0], 4'h0);
         else apply(1'b1, 1'b0, 1'b0, k[0], `CMD_SINGLE_PULSE);
         `CHECK_EQ(ciInd, k ? i_dut.IND_DEACT_REQ : i_dut.IND_INACTIVE)
         expLvl = `PULSE_LEVEL_NEG;
         gap = 0;
         while (pulseStrobe !== 1'b1 && gap < SPC + 4) begin
            @(negedge clk_sys);
            gap++;
         end
         for (int p = 0; p < 3; p++) begin
            expLvl = -expLvl;
            `CHECK_EQ(pulseStrobe, 1'b1)
            `CHECK_EQ(pulseLevel, expLvl)
            gap = 0;
            do begin
               @(negedge clk_sys);
               gap++;
            end while (pulseStrobe !== 1'b1 && gap < SPC + 4);
            if (p < 2) `CHECK_EQ(gap, SPC)
         end
         apply(1'b1, 1'b0, 1'b0, 1'b0, 4'h0);
      end
   endtask
   task test_supply;
      apply(1'b1, 1'b0, 1'b1, 1'b0, 4'h0);
      `CHECK_EQ(lineSilent, 1'b1)
      `CHECK_EQ(ciInd, i_dut.IND_POWER_DOWN)
      apply(1'b1, 1'b0, 1'b1, 1'b1, 4'h0);
      `CHECK_EQ(lineSilent, 1'b0)
      apply(1'b1, 1'b0, 1'b0, 1'b0, `CMD_LT_POWER_DOWN);
      `CHECK_EQ(activationRefuse, 1'b1)
      `CHECK_EQ(supplyDisablePin, 1'b1)
      `CHECK_EQ(ciInd, i_dut.IND_INACTIVE)
      apply(1'b1, 1'b0, 1'b0, 1'b1, `CMD_LT_POWER_DOWN);
      `CHECK_EQ(supplyDisablePin, 1'b0)
      `CHECK_EQ(lineSilent, 1'b0)
      apply(1'b1, 1'b0, 1'b0, 1'b0, 4'h0);
   endtask
   // wait for n reply words, bounded
   task await_words(input int n);
      for (int i = 0; i < 40 && i_partner.txWords.size() < n; i++) @(negedge clk_sys);
   endtask
   task test_self_check;
      logic [15:0] gotWord;
      apply(1'b1, 1'b0, 1'b0, 1'b1, 4'h0);
      i_partner.send_word(i_dut.CHECK_REQ_WORD);
      await_words(1);
      `CHECK_EQ(i_partner.txWords.size(), 1)
      if (i_partner.txWords.size() > 0) begin
         gotWord = i_partner.txWords.pop_front();
         `CHECK_EQ(gotWord, i_dut.CHECK_PASS_WORD)
      end
      apply(1'b1, 1'b0, 1'b0, 1'b0, 4'h0);
      i_partner.send_word(i_dut.CHECK_REQ_WORD);
      await_words(1);
      `CHECK_EQ(i_partner.txWords.size(), 0)
   endtask
   task test_reg_read;
      i_partner.slow = 1'b1;
      i_partner.send_word({i_dut.REG_ACCESS_BYTE, 8'h5A});
      await_words(2);
      i_partner.send_word({i_dut.REG_ACCESS_BYTE, 8'hC3});
      await_words(4);
      `CHECK_EQ(i_partner.txWords.size(), 4)
      if (i_partner.txWords.size() == 4) begin
         `CHECK_EQ(i_partner.txWords[0], {`MON_REPLY_BYTE, 8'h5A})
         `CHECK_EQ(i_partner.txWords[1], {`MON_REPLY_BYTE, 8'hA5})
         `CHECK_EQ(i_partner.txWords[2], {`MON_REPLY_BYTE, 8'hC3})
         `CHECK_EQ(i_partner.txWords[3], {`MON_REPLY_BYTE, 8'h3C})
      end
      i_partner.slow = 1'b0;
   endtask
   initial begin
      repeat (3) @(negedge clk_sys);
      `CHECK_EQ(lineSilent, 1'b1)
      `CHECK_EQ(ciInd, i_dut.IND_INACTIVE)
      @(negedge clk_sys);
      reset = 1'b0;
      test_master_reset();
      test_data_through();
      test_single_pulse();
      test_supply();
      test_self_check();
      test_reg_read();
      wrap_up();
   end
endmodule // tb_line_transceiver_test_mode_control
`default_nettype wire
